// ---- logic/atb_timer.sv ----
// advanced timer slice: time base, repetition, slave control, input channels
`include "atb_consts.svh"
module atb_timer
	import atb_pkg::*;
(
	input  wire logic                  sys_clk,
	input  wire logic                  rstn,
	input  wire atb_ctrl_t             ctrl,
	input  wire logic                  force_update_bit,
	input  wire logic                  update_flag_clr,
	input  wire logic                  trigger_flag_clr,
	input  wire logic [`ATB_NCH-1:0]   timer_input_pin,
	input  wire atb_chan_cfg_t         chan_cfg [`ATB_NCH],
	input  wire atb_chan_sw_t          chan_sw  [`ATB_NCH],
	output logic [`ATB_CNT_W-1:0]      count_value,
	output logic                       dir_down,
	output logic [`ATB_REP_W-1:0]      repeat_value,
	output logic                       update_event,
	output logic                       update_event_flag,
	output logic                       trigger_flag,
	output logic [`ATB_NCH-1:0]        filtered_input,
	output atb_chan_stat_t             chan_stat [`ATB_NCH]
);

	atb_tb_state_t               s_reg;
	atb_tb_state_t               s_next;
	logic [`ATB_NCH-1:0]         in_rise;
	logic [`ATB_NCH-1:0]         in_fall;
	logic                        trig_edge;
	logic                        forced;
	logic                        psc_in;
	logic                        tick;
	logic                        center;
	logic                        ovf;
	logic                        udf;
	logic                        hw_upd;
	logic                        upd;
	logic [`ATB_CNT_W-1:0]       reload_new;

	// ----------------------------------------------------------------
	// input stages and channels
	// ----------------------------------------------------------------
	for (genvar i = 0; i < `ATB_NCH; i++) begin : g_ch
		atb_input_stage u_in (
			.sys_clk           (sys_clk),
			.rstn              (rstn),
			.timer_input_pin   (timer_input_pin[i]),
			.input_filter_code (chan_cfg[i].input_filter_code),
			.filtered_input    (filtered_input[i]),
			.rise              (in_rise[i]),
			.fall              (in_fall[i])
		);
		atb_capture_chan u_ch (
			.sys_clk    (sys_clk),
			.rstn       (rstn),
			.cfg        (chan_cfg[i]),
			.sw         (chan_sw[i]),
			.own_rise   (in_rise[i]),
			.own_fall   (in_fall[i]),
			.cross_rise (in_rise[`ATB_NCH-1-i]),
			.cross_fall (in_fall[`ATB_NCH-1-i]),
			.cnt_value  (s_reg.cnt),
			.cnt_tick   (tick),
			.stat       (chan_stat[i])
		);
	end

	// ----------------------------------------------------------------
	// time base
	// ----------------------------------------------------------------
	always_comb begin
		s_next              = s_reg;
		s_next.run_d        = ctrl.count_run_bit;
		s_next.update_event = 1'b0;
		center              = ctrl.count_mode != `ATB_CMS_EDGE;
		// only channel one and two edge signals reach the slave controller
		unique case (ctrl.trigger_select)
			`ATB_TS_FIRST:  trig_edge = chan_stat[0].edge_trigger_signal;
			`ATB_TS_SECOND: trig_edge = chan_stat[1].edge_trigger_signal;
			default:        trig_edge = 1'b0;
		endcase
		forced = force_update_bit ||
			(ctrl.slave_mode_select == `ATB_SMS_RESET && trig_edge);
		psc_in = s_reg.run_d && ((ctrl.slave_mode_select == `ATB_SMS_EXT1) ?
			trig_edge : 1'b1);
		tick   = 1'b0;
		if (psc_in) begin
			if (s_reg.psc_cnt >= s_reg.psc_active) begin
				s_next.psc_cnt = '0;
				tick           = 1'b1;
			end else begin
				s_next.psc_cnt = s_reg.psc_cnt + 16'h1;
			end
		end
		// wrap detection first, so the reload used below can follow the update
		ovf = 1'b0;
		udf = 1'b0;
		if (tick) begin
			if (center) begin
				if (!s_reg.dir_down) begin
					ovf = s_reg.cnt + 16'h1 >= s_reg.reload_active;
				end else begin
					udf = s_reg.cnt <= 16'h1;
				end
			end else if (!s_reg.dir_down) begin
				ovf = s_reg.cnt >= s_reg.reload_active;
			end else begin
				udf = s_reg.cnt == '0;
			end
		end
		hw_upd = 1'b0;
		if (ovf || udf) begin
			if (s_reg.rep_cnt == '0) begin
				hw_upd         = 1'b1;
				s_next.rep_cnt = ctrl.repeat_count_reg;
			end else begin
				s_next.rep_cnt = s_reg.rep_cnt - 8'h1;
			end
		end
		upd        = (hw_upd || forced) && !ctrl.update_inhibit;
		reload_new = upd ? ctrl.reload_value_reg : s_reg.reload_active;
		if (upd) begin
			s_next.update_event  = 1'b1;
			s_next.reload_active = ctrl.reload_value_reg;
			s_next.psc_active    = ctrl.prescale_reg;
			s_next.rep_cnt       = ctrl.repeat_count_reg;
		end
		// counter and direction
		if (!center) begin
			s_next.dir_down = ctrl.dir_sw;
		end
		if (forced) begin
			// restart happens even with updates inhibited
			s_next.psc_cnt = '0;
			s_next.cnt     = (!center && ctrl.dir_sw) ? reload_new : '0;
		end else if (tick) begin
			if (center) begin
				if (ovf) begin
					// an update at this turn already brings the new top value
					s_next.cnt      = reload_new;
					s_next.dir_down = 1'b1;
				end else if (udf) begin
					s_next.cnt      = '0;
					s_next.dir_down = 1'b0;
				end else if (s_reg.dir_down) begin
					s_next.cnt = s_reg.cnt - 16'h1;
				end else begin
					s_next.cnt = s_reg.cnt + 16'h1;
				end
			end else if (ovf) begin
				s_next.cnt = '0;
			end else if (udf) begin
				s_next.cnt = reload_new;
			end else if (s_reg.dir_down) begin
				s_next.cnt = s_reg.cnt - 16'h1;
			end else begin
				s_next.cnt = s_reg.cnt + 16'h1;
			end
		end
		// flags: clear before set so a same-cycle event is kept
		if (update_flag_clr) begin
			s_next.update_event_flag = 1'b0;
		end
		if (upd && !(forced && !hw_upd && ctrl.update_source_select)) begin
			s_next.update_event_flag = 1'b1;
		end
		if (trigger_flag_clr) begin
			s_next.trigger_flag = 1'b0;
		end
		if (trig_edge && (ctrl.slave_mode_select == `ATB_SMS_EXT1 ||
			ctrl.slave_mode_select == `ATB_SMS_RESET)) begin
			s_next.trigger_flag = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign count_value       = s_reg.cnt;
	assign dir_down          = s_reg.dir_down;
	assign repeat_value      = s_reg.rep_cnt;
	assign update_event      = s_reg.update_event;
	assign update_event_flag = s_reg.update_event_flag;
	assign trigger_flag      = s_reg.trigger_flag;

endmodule

// ---- logic/atb_consts.svh ----
// constants for the advanced timer time-base and capture slice
//
// Summary of operation
// - center mode: up to reload, down to 0
// - center mode ignores software direction writes
// - updates at wraps and forced; forced restarts counters
// - update_inhibit blocks updates, counting continues
// - update_source_select hides flag on forced update
// - update reloads repeat, reload, sets flag
// - overflow update loads reload before counter reload
// - hardware update only when repeat count zero
// - repeat counts overflow, underflow, or both
// - forced update ignores repeat count, reloads it
// - slave off: software bits, run uses internal clock
// - external clock one counts trigger edges, flags
// - trigger select: 01 first, 10 second input
// - input: filter, edge polarity, event prescale, capture
// - filter code 0011 needs eight stable samples
// - input map: 00 output, 01 own, 10 cross
// - capture latches counter, sets flag, interrupt
// - overcapture flag; flag clears by write/read
// - soft channel event acts like hardware event
// - polarity 0 rising, 1 falling edge
// - slave reset mode clears counter on trigger, loads reload when edge mode counts down
// - forced output reference high 101, low 100
// - counting starts one cycle after run set
// - prescale ratio buffered until update event
`ifndef ATB_CONSTS_SVH
`define ATB_CONSTS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define ATB_CNT_W        16
`define ATB_REP_W        8
`define ATB_NCH          2
`define ATB_FILT_W       4

// ----------------------------------------------------------------
// mode codes
// ----------------------------------------------------------------
`define ATB_CMS_EDGE     2'b00
`define ATB_SMS_OFF      3'b000
`define ATB_SMS_RESET    3'b100
`define ATB_SMS_EXT1     3'b111
`define ATB_TS_FIRST     2'b01
`define ATB_TS_SECOND    2'b10
`define ATB_MAP_OUTPUT   2'b00
`define ATB_MAP_OWN      2'b01
`define ATB_MAP_CROSS    2'b10
`define ATB_OC_FORCE_HI  3'b101
`define ATB_OC_FORCE_LO  3'b100
`define ATB_POL_RISE     1'b0

// ----------------------------------------------------------------
// filter sample counts
// ----------------------------------------------------------------
`define ATB_FILT_LEN0    4'h1
`define ATB_FILT_LEN1    4'h2
`define ATB_FILT_LEN2    4'h4
`define ATB_FILT_LEN3    4'h8
`define ATB_FILT_CODE0   4'h0
`define ATB_FILT_CODE1   4'h1
`define ATB_FILT_CODE2   4'h2
`define ATB_FILT_CODE3   4'h3

`endif

// ---- logic/atb_pkg.sv ----
// types shared by the timer slice modules
`include "atb_consts.svh"

package atb_pkg;

	typedef struct packed {
		logic                   count_run_bit;
		logic [1:0]             count_mode;
		logic                   dir_sw;
		logic                   update_inhibit;
		logic                   update_source_select;
		logic [2:0]             slave_mode_select;
		logic [1:0]             trigger_select;
		logic [`ATB_CNT_W-1:0]  reload_value_reg;
		logic [`ATB_CNT_W-1:0]  prescale_reg;
		logic [`ATB_REP_W-1:0]  repeat_count_reg;
	} atb_ctrl_t;

	typedef struct packed {
		logic [1:0]             channel_input_map;
		logic [`ATB_FILT_W-1:0] input_filter_code;
		logic [1:0]             input_event_prescale;
		logic                   channel_polarity;
		logic                   channel_capture_enable;
		logic                   channel_irq_enable;
		logic [2:0]             output_compare_select;
	} atb_chan_cfg_t;

	typedef struct packed {
		logic                   channel_soft_event;
		logic                   value_wr;
		logic [`ATB_CNT_W-1:0]  value_wr_data;
		logic                   value_rd;
		logic                   event_flag_clr;
		logic                   overrun_flag_clr;
	} atb_chan_sw_t;

	typedef struct packed {
		logic [`ATB_CNT_W-1:0]  channel_value_reg;
		logic                   channel_event_flag;
		logic                   channel_overrun_flag;
		logic                   channel_irq;
		logic                   output_reference;
		logic                   output_pin;
		logic                   edge_trigger_signal;
	} atb_chan_stat_t;

	typedef struct packed {
		logic                   sync1;
		logic                   sync2;
		logic                   filtered_input;
		logic [`ATB_FILT_W-1:0] stable_cnt;
		logic                   rise;
		logic                   fall;
	} atb_in_state_t;

	typedef struct packed {
		logic [`ATB_CNT_W-1:0]  value;
		logic                   event_flag;
		logic                   overrun_flag;
		logic                   oref;
		logic [2:0]             ps_cnt;
	} atb_chan_state_t;

	typedef struct packed {
		logic                   run_d;
		logic                   dir_down;
		logic [`ATB_CNT_W-1:0]  cnt;
		logic [`ATB_CNT_W-1:0]  psc_cnt;
		logic [`ATB_CNT_W-1:0]  psc_active;
		logic [`ATB_CNT_W-1:0]  reload_active;
		logic [`ATB_REP_W-1:0]  rep_cnt;
		logic                   update_event;
		logic                   update_event_flag;
		logic                   trigger_flag;
	} atb_tb_state_t;

endpackage

// ---- logic/atb_input_stage.sv ----
// timer input synchroniser, digital filter and edge pulses
`include "atb_consts.svh"
module atb_input_stage
	import atb_pkg::*;
(
	input  wire logic                   sys_clk,
	input  wire logic                   rstn,
	input  wire logic                   timer_input_pin,
	input  wire logic [`ATB_FILT_W-1:0] input_filter_code,
	output logic                        filtered_input,
	output logic                        rise,
	output logic                        fall
);

	atb_in_state_t s_reg;
	atb_in_state_t s_next;

	// codes above the documented set fall back to the longest window
	function automatic logic [`ATB_FILT_W-1:0] filt_len(input logic [`ATB_FILT_W-1:0] code);
		unique case (code)
			`ATB_FILT_CODE0: filt_len = `ATB_FILT_LEN0;
			`ATB_FILT_CODE1: filt_len = `ATB_FILT_LEN1;
			`ATB_FILT_CODE2: filt_len = `ATB_FILT_LEN2;
			`ATB_FILT_CODE3: filt_len = `ATB_FILT_LEN3;
			default:         filt_len = `ATB_FILT_LEN3;
		endcase
	endfunction

	always_comb begin
		s_next       = s_reg;
		s_next.sync1 = timer_input_pin;
		s_next.sync2 = s_reg.sync1;
		s_next.rise  = 1'b0;
		s_next.fall  = 1'b0;
		if (s_reg.sync2 == s_reg.filtered_input) begin
			s_next.stable_cnt = '0;
		end else if (s_reg.stable_cnt + 4'h1 >= filt_len(input_filter_code)) begin
			s_next.filtered_input = s_reg.sync2;
			s_next.stable_cnt     = '0;
			s_next.rise           = s_reg.sync2;
			s_next.fall           = ~s_reg.sync2;
		end else begin
			s_next.stable_cnt = s_reg.stable_cnt + 4'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign filtered_input = s_reg.filtered_input;
	assign rise           = s_reg.rise;
	assign fall           = s_reg.fall;

endmodule

// ---- logic/atb_capture_chan.sv ----
// one capture/compare channel: edge select, event prescale, capture, flags
`include "atb_consts.svh"
module atb_capture_chan
	import atb_pkg::*;
(
	input  wire logic                  sys_clk,
	input  wire logic                  rstn,
	input  wire atb_chan_cfg_t         cfg,
	input  wire atb_chan_sw_t          sw,
	input  wire logic                  own_rise,
	input  wire logic                  own_fall,
	input  wire logic                  cross_rise,
	input  wire logic                  cross_fall,
	input  wire logic [`ATB_CNT_W-1:0] cnt_value,
	input  wire logic                  cnt_tick,
	output atb_chan_stat_t             stat
);

	atb_chan_state_t s_reg;
	atb_chan_state_t s_next;
	logic            is_input;
	logic            sel_rise;
	logic            sel_fall;
	logic            cap_cmd;
	logic            fire;
	logic            cap_event;
	logic            cmp_event;

	always_comb begin
		s_next    = s_reg;
		is_input  = cfg.channel_input_map != `ATB_MAP_OUTPUT;
		sel_rise  = (cfg.channel_input_map == `ATB_MAP_CROSS) ? cross_rise : own_rise;
		sel_fall  = (cfg.channel_input_map == `ATB_MAP_CROSS) ? cross_fall : own_fall;
		cap_cmd   = is_input &&
			((cfg.channel_polarity == `ATB_POL_RISE) ? sel_rise : sel_fall);
		fire      = 1'b0;
		// event prescale: capture on every 1st, 2nd, 4th or 8th edge
		if (cap_cmd) begin
			if (s_reg.ps_cnt == 3'((4'h1 << cfg.input_event_prescale) - 4'h1)) begin
				s_next.ps_cnt = '0;
				fire          = 1'b1;
			end else begin
				s_next.ps_cnt = s_reg.ps_cnt + 3'h1;
			end
		end
		cap_event = is_input && ((fire && cfg.channel_capture_enable) ||
			sw.channel_soft_event);
		cmp_event = !is_input && ((cnt_tick && cnt_value == s_reg.value) ||
			sw.channel_soft_event);
		// software may only write the value while the channel is an output
		if (!is_input && sw.value_wr) begin
			s_next.value = sw.value_wr_data;
		end
		// clears first so that a simultaneous event wins
		if (sw.event_flag_clr || sw.value_rd) begin
			s_next.event_flag = 1'b0;
		end
		if (sw.overrun_flag_clr) begin
			s_next.overrun_flag = 1'b0;
		end
		if (cap_event) begin
			s_next.value = cnt_value;
			if (s_reg.event_flag) begin
				s_next.overrun_flag = 1'b1;
			end
		end
		if (cap_event || cmp_event) begin
			s_next.event_flag = 1'b1;
		end
		if (cfg.output_compare_select == `ATB_OC_FORCE_HI) begin
			s_next.oref = 1'b1;
		end else if (cfg.output_compare_select == `ATB_OC_FORCE_LO) begin
			s_next.oref = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	always_comb begin
		stat.channel_value_reg    = s_reg.value;
		stat.channel_event_flag   = s_reg.event_flag;
		stat.channel_overrun_flag = s_reg.overrun_flag;
		stat.channel_irq          = s_reg.event_flag & cfg.channel_irq_enable;
		stat.output_reference     = s_reg.oref;
		stat.output_pin           = s_reg.oref ^ cfg.channel_polarity;
		// slave trigger always uses this channel's own input
		stat.edge_trigger_signal  =
			(cfg.channel_polarity == `ATB_POL_RISE) ? own_rise : own_fall;
	end

endmodule

// ---- verif/atb_timer_assertions.sv ----
// concurrent checks on the timer slice top-level ports
`include "atb_consts.svh"

module atb_timer_chk
	import atb_pkg::*;
(
	input wire logic                  sys_clk,
	input wire logic                  rstn,
	input wire atb_ctrl_t             ctrl,
	input wire logic                  force_update_bit,
	input wire atb_chan_cfg_t         chan_cfg [`ATB_NCH],
	input wire logic [`ATB_CNT_W-1:0] count_value,
	input wire logic                  dir_down,
	input wire logic [`ATB_REP_W-1:0] repeat_value,
	input wire logic                  update_event,
	input wire logic                  update_event_flag,
	input wire atb_chan_stat_t        chan_stat [`ATB_NCH]
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	// ----------------------------------------------------------------
	// update sequences: event pulse with or without its flag, pulse gone next cycle unless forced again
	// ----------------------------------------------------------------
	sequence shown_upd_s;
		(update_event && update_event_flag) ##1 (!update_event || $past(force_update_bit));
	endsequence
	sequence hidden_upd_s;
		(update_event && !update_event_flag) ##1 (!update_event || $past(force_update_bit));
	endsequence

	center_turn_a: assert property (ctrl.count_mode != 2'b00 && $past(ctrl.count_mode) != 2'b00
		&& $fell(dir_down) |-> count_value == 16'h0000) else $error("turn up away from zero");
	force_restart_a: assert property (force_update_bit && ctrl.count_mode != 2'b00
		|=> count_value == 16'h0000) else $error("forced update did not restart");
	force_flag_a: assert property (force_update_bit && !ctrl.update_inhibit
		&& !ctrl.update_source_select |=> shown_upd_s) else $error("forced update lost");
	urs_hide_a: assert property (force_update_bit && ctrl.update_source_select
		&& !ctrl.update_inhibit && !ctrl.count_run_bit && !$past(ctrl.count_run_bit)
		&& !update_event_flag |=> hidden_upd_s) else $error("hidden update wrong");
	inhibit_hold_a: assert property (ctrl.update_inhibit && !update_event_flag
		|=> !update_event_flag) else $error("flag set while inhibited");
	flag_event_a: assert property ($rose(update_event_flag)
		|-> repeat_value == $past(ctrl.repeat_count_reg) && update_event)
		else $error("update reload");
	capture_latch_a: assert property ($rose(chan_stat[0].channel_event_flag)
		&& chan_cfg[0].channel_input_map != 2'b00
		|-> chan_stat[0].channel_value_reg == $past(count_value)) else $error("capture value");
	overrun_cause_a: assert property ($rose(chan_stat[1].channel_overrun_flag)
		|-> $past(chan_stat[1].channel_event_flag)) else $error("overrun without flag");
	force_level_a: assert property (chan_cfg[0].channel_input_map == 2'b00
		&& chan_cfg[0].output_compare_select[2:1] == 2'b10 |=> chan_stat[0].output_reference
		== $past(chan_cfg[0].output_compare_select[0])) else $error("forced level");
endmodule

bind atb_timer atb_timer_chk chk (.sys_clk, .rstn, .ctrl, .force_update_bit, .chan_cfg,
	.count_value, .dir_down, .repeat_value, .update_event, .update_event_flag, .chan_stat);

// ---- verif/atb_pulse_src.sv ----
// pulse source standing in for the signals wired to the timer inputs
module atb_pulse_src (
	input  wire logic  sys_clk,
	output logic [1:0] timer_input_pin
);
	timeunit 1ns;
	timeprecision 100ps;

	initial timer_input_pin = 2'b00;

	// widths in clock cycles, so short glitches and slow pulses both fit
	task automatic pulse(input int ch, input int hi, input int lo);
		@(negedge sys_clk);
		timer_input_pin[ch] = 1'b1;
		repeat (hi) @(negedge sys_clk);
		timer_input_pin[ch] = 1'b0;
		repeat (lo) @(negedge sys_clk);
	endtask
endmodule

// ---- verif/adv_timer_timebase_capture_bench.sv ----
// self-checking bench for the timer slice
`include "atb_consts.svh"

module adv_timer_timebase_capture_bench
	import atb_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic                  sys_clk = 1'b0;
	logic                  rstn, force_update_bit, update_flag_clr, trigger_flag_clr;
	atb_ctrl_t             ctrl;
	atb_chan_cfg_t         cfg [`ATB_NCH];
	atb_chan_sw_t          sw [`ATB_NCH];
	atb_chan_stat_t        st [`ATB_NCH];
	logic [1:0]            pins, filtered_input;
	logic [`ATB_CNT_W-1:0] count_value;
	logic [`ATB_REP_W-1:0] repeat_value;
	logic                  dir_down, update_event, update_event_flag, trigger_flag;
	int                    failures, samples_checked, cyc;

	atb_timer dut (.sys_clk, .rstn, .ctrl, .force_update_bit, .update_flag_clr,
		.trigger_flag_clr, .timer_input_pin(pins), .chan_cfg(cfg), .chan_sw(sw), .count_value,
		.dir_down, .repeat_value, .update_event, .update_event_flag, .trigger_flag,
		.filtered_input, .chan_stat(st));
	atb_pulse_src src (.sys_clk, .timer_input_pin(pins));

	always #12.5 sys_clk = ~sys_clk;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic tk(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic fpulse;
		force_update_bit = 1'b1;
		tk(1);
		force_update_bit = 1'b0;
	endtask
	task automatic uclr;
		update_flag_clr = 1'b1;
		tk(1);
		update_flag_clr = 1'b0;
	endtask
	task automatic cclr;
		for (int i = 0; i < 2; i++) begin
			sw[i].event_flag_clr = 1'b1;
			sw[i].overrun_flag_clr = 1'b1;
		end
		tk(1);
		for (int i = 0; i < 2; i++) sw[i] = '0;
	endtask
	// soft event, write, read, overrun clear on channel one
	task automatic sw0(input logic [3:0] m);
		sw[0] = {m[3], m[2], 16'h1234, m[1], 1'b0, m[0]};
		tk(1);
		sw[0] = '0;
		tk(1);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 4000) begin
			failures++;
			stop_test();
		end
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		chk({count_value, repeat_value, update_event_flag, trigger_flag,
			st[0].channel_event_flag, st[0].channel_overrun_flag}, 32'h0);
		for (int i = 4; i < 6; i++) begin
			cfg[0].output_compare_select = 3'(i);
			cfg[0].channel_polarity = 1'b1;
			tk(2);
			chk(st[0].output_reference, 32'(i % 2));
			chk(st[0].output_pin, 32'(1 - i % 2));
		end
		cfg[0] = '0;
		// two synchroniser flops plus the one-sample filter
		src.pulse(1, 2, 0);
		chk(filtered_input, 32'h0);
		tk(1);
		chk(filtered_input, 32'h2);
		$display("test reset done");
	endtask

	task automatic t_start;
		ctrl.reload_value_reg = 16'h0002;
		ctrl.repeat_count_reg = 8'h01;
		fpulse;
		chk(repeat_value, 32'h1);
		uclr;
		ctrl.count_run_bit = 1'b1;
		tk(1);
		chk(count_value, 32'h0);
		tk(1);
		chk(count_value, 32'h1);
		tk(4);
		chk(update_event_flag, 32'h0);
		tk(1);
		chk(update_event_flag, 32'h1);
		ctrl.count_run_bit = 1'b0;
		tk(2);
		uclr;
		$display("test start done");
	endtask

	task automatic t_center;
		ctrl.count_mode = 2'b01;
		ctrl.reload_value_reg = 16'h0003;
		ctrl.repeat_count_reg = 8'h00;
		fpulse;
		uclr;
		ctrl.count_run_bit = 1'b1;
		tk(1);
		for (int i = 1; i < 13; i++) begin
			tk(1);
			ctrl.dir_sw = 1'(i);
			chk(count_value, (i % 6 <= 3) ? i % 6 : 6 - i % 6);
			chk(dir_down, 32'(i % 6 >= 3));
		end
		ctrl.count_run_bit = 1'b0;
		ctrl.dir_sw = 1'b0;
		tk(2);
		ctrl.count_mode = 2'b00;
		uclr;
		$display("test center done");
	endtask

	task automatic t_force;
		for (int k = 0; k < 3; k++) begin
			ctrl.update_source_select = (k == 0);
			ctrl.update_inhibit = (k == 1);
			fpulse;
			chk(update_event_flag, (k == 2));
			chk(update_event, (k != 1));
			tk(1);
			uclr;
		end
		ctrl.update_source_select = 1'b0;
		ctrl.update_inhibit = 1'b0;
		$display("test force done");
	endtask

	task automatic t_ext;
		ctrl.reload_value_reg = 16'h00ff;
		ctrl.slave_mode_select = 3'b111;
		ctrl.count_run_bit = 1'b1;
		cfg[0].channel_input_map = 2'b01;
		cfg[1].channel_input_map = 2'b01;
		for (int k = 1; k < 3; k++) begin
			ctrl.trigger_select = 2'(k);
			fpulse;
			trigger_flag_clr = 1'b1;
			tk(1);
			trigger_flag_clr = 1'b0;
			repeat (3) src.pulse(k - 1, 3, 3);
			src.pulse(2 - k, 3, 3);
			tk(6);
			chk(count_value, 32'h3);
			chk(trigger_flag, 32'h1);
		end
		ctrl.slave_mode_select = 3'b000;
		ctrl.count_run_bit = 1'b0;
		$display("test external clock done");
	endtask

	task automatic t_filter;
		cfg[0].input_filter_code = 4'h3;
		cfg[0].channel_capture_enable = 1'b1;
		cclr;
		src.pulse(0, 7, 12);
		chk(st[0].channel_event_flag, 32'h0);
		src.pulse(0, 9, 12);
		chk(st[0].channel_event_flag, 32'h1);
		cfg[0].input_filter_code = 4'h0;
		$display("test filter done");
	endtask

	task automatic t_capture;
		logic [15:0] v;
		fpulse;
		ctrl.count_run_bit = 1'b1;
		cfg[0].channel_irq_enable = 1'b1;
		cfg[1] = '{2'b10, 4'h0, 2'b00, 1'b1, 1'b1, 1'b0, 3'h0};
		cclr;
		src.pulse(0, 5, 7);
		chk(st[0].channel_irq, 32'h1);
		chk(16'(st[1].channel_value_reg - st[0].channel_value_reg), 32'h5);
		src.pulse(0, 5, 7);
		chk({st[0].channel_overrun_flag, st[1].channel_overrun_flag}, 32'h3);
		v = st[0].channel_value_reg;
		sw0(4'b0110);
		chk({st[0].channel_value_reg, st[0].channel_event_flag, st[0].channel_overrun_flag},
			{v, 2'b01});
		sw0(4'b0001);
		chk(st[0].channel_overrun_flag, 32'h0);
		sw0(4'b1000);
		chk(st[0].channel_irq, 32'h1);
		ctrl.slave_mode_select = 3'b100;
		ctrl.trigger_select = 2'b01;
		repeat (3) src.pulse(0, 5, 7);
		// low phase is lo plus the idle cycle the next pulse waits for
		chk(16'(st[0].channel_value_reg - st[1].channel_value_reg), 32'h8);
		ctrl.slave_mode_select = 3'b000;
		ctrl.count_run_bit = 1'b0;
		$display("test capture done");
	endtask

	initial begin
		rstn = 1'b0;
		ctrl = '0;
		force_update_bit = 1'b0;
		update_flag_clr = 1'b0;
		trigger_flag_clr = 1'b0;
		for (int i = 0; i < 2; i++) begin
			cfg[i] = '0;
			sw[i] = '0;
		end
		tk(6);
		rstn = 1'b1;
		t_reset;
		t_start;
		t_center;
		t_force;
		t_ext;
		t_filter;
		t_capture;
		stop_test;
	end
endmodule
